/* File: dv/ssf_host_model.sv */
`timescale 1ns/100ps
module ssf_host_model
	import ssf_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	// Requests from the bench
	input  wire logic                      go_i,
	input  wire logic [2:0]                op_i,
	// Query and reset command strobes
	output logic [4:0]                     strobe_o,
	// Answer from the block
	input  wire logic                      answer_valid_i,
	input  wire logic [ssf_pkg::COND_W-1:0] answer_value_i,
	output logic [ssf_pkg::COND_W-1:0]     got_o,
	output logic                           done_o
);
	// One strobe per request; the answer is taken at the edge seeing valid
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strobe_o <= 5'h00;
			got_o    <= 13'h0000;
			done_o   <= 1'b0;
		end else begin
			strobe_o <= go_i ? 5'(5'h01 << op_i) : 5'h00;
			done_o   <= answer_valid_i || strobe_o[4];
			if (answer_valid_i) begin
				got_o <= answer_value_i;
			end
		end
	end
endmodule : ssf_host_model

/* File: dv/supply_status_fault_regs_tb.sv */
`timescale 1ns/100ps
module supply_status_fault_regs_tb;
	import ssf_pkg::*;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic [12:0] cond = 13'h0000;
	logic [11:0] ev = 12'h000;
	logic        go = 1'b0;
	logic [2:0]  op_q = 3'h0;
	logic        mask_wr = 1'b0;
	logic [12:0] mask_d = 13'h1fff;
	logic [4:0]  stb;
	logic        av, done, err_led, sp_err;
	logic [2:0]  leds;
	ssf_src_t    src;
	logic [12:0] val, got, live_r, lat_r, mask_r, fail_r, e;
	logic [15:0] bcd_r;
	int          mismatches = 0;
	int          n_tests = 0;
	logic [3:0]  codes [9] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
		4'ha, 4'hc, 4'h7};

	always #50 clk_i = ~clk_i;

	ssf_host_model u_host (.clk_i(clk_i), .resetn_i(resetn_i),
		.go_i(go), .op_i(op_q), .strobe_o(stb),
		.answer_valid_i(av), .answer_value_i(val),
		.got_o(got), .done_o(done));

	// Bit 2 and the mistake/power-up bits have no pin on purpose
	ssf_regs u_dut (.clk_i(clk_i), .resetn_i(resetn_i),
		.const_voltage_flag_i(cond[0]),
		.const_current_flag_i(cond[1]),
		.high_voltage_trip_flag_i(cond[3]),
		.thermal_trip_flag_i(cond[4]), .ext_shutdown_flag_i(cond[5]),
		.limit_backoff_flag_i(cond[6]), .host_control_flag_i(cond[9]),
		.mains_fail_flag_i(cond[10]), .output_fail_flag_i(cond[11]),
		.sense_trip_flag_i(cond[12]),
		.latched_state_query_i(stb[0]), .live_state_query_i(stb[1]),
		.failure_query_i(stb[2]), .mistake_code_query_i(stb[3]),
		.reset_cmd_i(stb[4]), .mask_wr_i(mask_wr),
		.mask_data_i(mask_d), .bad_char_i(ev[0]),
		.out_of_range_i(ev[1]), .over_soft_limit_i(ev[2]),
		.bad_soft_limit_i(ev[3]), .talk_no_query_i(ev[4]),
		.trip_below_output_i(ev[5]), .aux_cpu_timeout_i(ev[6]),
		.cal_locked_i(ev[7]), .ceiling_reject_i(ev[8]),
		.opcode_recovery_i(ev[9]), .master_restart_i(ev[10]),
		.aux_restart_i(ev[11]), .answer_valid_o(av),
		.answer_src_o(src), .answer_value_o(val),
		.answer_bcd_o(bcd_r), .live_condition_register_o(live_r),
		.latched_condition_register_o(lat_r),
		.failure_condition_register_o(fail_r), .cond_mask_o(mask_r),
		.serial_poll_mistake_o(sp_err), .error_led_o(err_led),
		.watchdog_recovery_led_o(leds[2]),
		.master_restart_led_o(leds[1]), .aux_restart_led_o(leds[0]));

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] bcd(input logic [12:0] v);
		int n;
		n = int'(v);
		return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
	endfunction : bcd

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Pins pass two sync flops before they show, so allow settling time
	task automatic setc(input logic [12:0] v);
		@(posedge clk_i);
		cond <= v;
		tick(5);
	endtask : setc

	task automatic pulse(input int k);
		@(posedge clk_i);
		ev <= 12'(1 << k);
		@(posedge clk_i);
		ev <= 12'h000;
		tick(1);
	endtask : pulse

	task automatic wmask(input logic [12:0] v);
		@(posedge clk_i);
		mask_wr <= 1'b1;
		mask_d <= v;
		@(posedge clk_i);
		mask_wr <= 1'b0;
		tick(1);
	endtask : wmask

	task automatic ask(input logic [2:0] op, input logic [12:0] exp,
		input bit chk);
		int n;
		@(posedge clk_i);
		go <= 1'b1;
		op_q <= op;
		@(posedge clk_i);
		go <= 1'b0;
		for (n = 0; n < 8 && done !== 1'b1; n++) begin
			@(posedge clk_i);
		end
		if (done !== 1'b1) begin
			mismatches++;
			wrap_up();
		end else if (chk && op != 3'h4) begin
			check(16'(got), 16'(exp));
			check(16'(src), 16'(op));
			check(bcd_r, bcd(exp));
		end
	endtask : ask

	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		tick(1);
		check(16'(mask_r), 16'h1fff);
		check(16'(lat_r), 16'h0100);
		setc(13'h0203);
		ask(3'h1, 13'h0303, 1'b1);
		setc(13'h0000);
		ask(3'h0, 13'h0303, 1'b1);
		ask(3'h0, 13'h0000, 1'b0);
		ask(3'h0, 13'h0000, 1'b1);
		ask(3'h2, 13'h0003, 1'b1);
		check(16'(fail_r), 16'h0000);
		for (int i = 0; i < 13; i++) begin
			if (i != 7 && i != 8) begin
				e = (i == 2) ? 13'h0000 : 13'(1 << i);
				setc(13'(1 << i));
				ask(3'h1, e, 1'b1);
				check(16'(live_r), 16'(e));
				setc(13'h0000);
				check(16'(fail_r), 16'(e & 13'h1cfb));
				ask(3'h2, e & 13'h1cfb, 1'b1);
				ask(3'h2, 13'h0000, 1'b1);
				ask(3'h0, e, 1'b1);
				ask(3'h0, 13'h0000, 1'b1);
			end
		end
		wmask(13'h1ffe);
		check(16'(mask_r), 16'h1ffa);
		setc(13'h0001);
		ask(3'h1, 13'h0001, 1'b1);
		setc(13'h0000);
		ask(3'h0, 13'h0000, 1'b1);
		wmask(13'h1fff);
		check(16'(mask_r), 16'h1ffb);
		for (int k = 0; k < 9; k++) begin
			pulse(k);
			check({err_led, sp_err, lat_r[7]}, 16'h0007);
			ask(3'h3, 13'(codes[k]), 1'b1);
			check({sp_err, lat_r[7], live_r[7]}, 16'h0000);
		end
		ask(3'h3, 13'h0000, 1'b1);
		for (int k = 0; k < 3; k++) begin
			pulse(9 + k);
			check(16'(leds), 16'(3'(3'b111 << (2 - k))));
		end
		ask(3'h4, 13'h0000, 1'b0);
		check(16'(leds), 16'h0000);
		wrap_up();
	end
endmodule : supply_status_fault_regs_tb

/* File: verilog/ssf_pkg.sv */
package ssf_pkg;
	// Condition bit positions, weight is 2**position
	localparam int COND_W             = 13;
	localparam int BIT_CONST_VOLTAGE  = 0;
	localparam int BIT_CONST_CURRENT  = 1;
	localparam int BIT_UNUSED         = 2;
	localparam int BIT_HIGH_V_TRIP    = 3;
	localparam int BIT_THERMAL_TRIP   = 4;
	localparam int BIT_EXT_SHUTDOWN   = 5;
	localparam int BIT_LIMIT_BACKOFF  = 6;
	localparam int BIT_PROG_MISTAKE   = 7;
	localparam int BIT_POWER_UP       = 8;
	localparam int BIT_HOST_CONTROL   = 9;
	localparam int BIT_MAINS_FAIL     = 10;
	localparam int BIT_OUTPUT_FAIL    = 11;
	localparam int BIT_SENSE_TRIP     = 12;

	// Bits that never exist in the failure register, and in the live register
	localparam logic [12:0] FAIL_ZERO_MASK = 13'h0304;
	localparam logic [12:0] LIVE_ZERO_MASK = 13'h0004;

	// Reset values
	localparam logic [12:0] MASK_RESET     = 13'h1fff;
	localparam logic [12:0] LATCHED_RESET  = 13'h0100;
	localparam logic [3:0]  CODE_RESET     = 4'h0;

	// Mistake codes
	localparam logic [3:0] CODE_NONE          = 4'h0;
	localparam logic [3:0] CODE_BAD_CHAR      = 4'h4;
	localparam logic [3:0] CODE_OUT_OF_RANGE  = 4'h5;
	localparam logic [3:0] CODE_OVER_SOFT_LIM = 4'h6;
	localparam logic [3:0] CODE_BAD_SOFT_LIM  = 4'h7;
	localparam logic [3:0] CODE_TALK_NO_QUERY = 4'h8;
	localparam logic [3:0] CODE_TRIP_BELOW    = 4'h9;
	localparam logic [3:0] CODE_AUX_TIMEOUT   = 4'ha;
	localparam logic [3:0] CODE_CAL_LOCKED    = 4'hc;

	// Which register an answer came from
	typedef enum logic [1:0] {
		SSF_SRC_LATCHED,
		SSF_SRC_LIVE,
		SSF_SRC_FAILURE,
		SSF_SRC_MISTAKE
	} ssf_src_t;
endpackage : ssf_pkg

/* File: verilog/ssf_regs.sv */
`timescale 1ns/100ps
// Function
// - Latched, live and failure registers always update, no enable needed.
// - A query answers the weighted sum of set bits in that register.
// - Bits 0,1 const voltage/current; 2 unused; 6 backoff; 10,11 fails.
// - Bits 3,4,12 report voltage, thermal and sense trips.
// - Bit 5 follows the external shutdown input.
// - Bits 8,9 exist only in latched and live; failure reads zero.
// - Condition bits can be masked out of latching by the host; a mistake event still sets latched bit 7.
// - Mistake code query clears mistake bit in latched, live, serial poll.
// - Latched register is returned then cleared by its query.
// - Failure register is returned then cleared by its query.
// - Mistake code query returns recorded code, zero when none.
// - Unrecognised character records code 4.
// - Out-of-range parameter records code 5.
// - Programming above soft limit records code 6.
// - Soft limit below output records code 7.
// - Talk without prior query records code 8.
// - Trip level below output voltage records code 9.
// - Secondary processor not responding records code 10.
// - Calibration command outside calibration mode records code 12.
// - Green LED on opcode recovery; red LEDs on processor restarts.
// - Reset command turns the green and both red LEDs off; the error LED stays.
// - Rejected ceiling command lights error LED and sets mistake bit.
module ssf_regs
	import ssf_pkg::*;
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	// Supply condition pins, asynchronous
	input  wire logic                 const_voltage_flag_i,
	input  wire logic                 const_current_flag_i,
	input  wire logic                 high_voltage_trip_flag_i,
	input  wire logic                 thermal_trip_flag_i,
	input  wire logic                 ext_shutdown_flag_i,
	input  wire logic                 limit_backoff_flag_i,
	input  wire logic                 host_control_flag_i,
	input  wire logic                 mains_fail_flag_i,
	input  wire logic                 output_fail_flag_i,
	input  wire logic                 sense_trip_flag_i,
	// Query and command strobes from the command parser
	input  wire logic                 latched_state_query_i,
	input  wire logic                 live_state_query_i,
	input  wire logic                 failure_query_i,
	input  wire logic                 mistake_code_query_i,
	input  wire logic                 reset_cmd_i,
	input  wire logic                 mask_wr_i,
	input  wire logic [COND_W-1:0]    mask_data_i,
	// Mistake events from the command parser
	input  wire logic                 bad_char_i,
	input  wire logic                 out_of_range_i,
	input  wire logic                 over_soft_limit_i,
	input  wire logic                 bad_soft_limit_i,
	input  wire logic                 talk_no_query_i,
	input  wire logic                 trip_below_output_i,
	input  wire logic                 aux_cpu_timeout_i,
	input  wire logic                 cal_locked_i,
	input  wire logic                 ceiling_reject_i,
	// Processor recovery events
	input  wire logic                 opcode_recovery_i,
	input  wire logic                 master_restart_i,
	input  wire logic                 aux_restart_i,
	// Answer
	output logic                      answer_valid_o,
	output ssf_pkg::ssf_src_t         answer_src_o,
	output logic [COND_W-1:0]         answer_value_o,
	output logic [15:0]               answer_bcd_o,
	// Live views
	output logic [COND_W-1:0]         live_condition_register_o,
	output logic [COND_W-1:0]         latched_condition_register_o,
	output logic [COND_W-1:0]         failure_condition_register_o,
	output logic [COND_W-1:0]         cond_mask_o,
	output logic                      serial_poll_mistake_o,
	// Indicators
	output logic                      error_led_o,
	output logic                      watchdog_recovery_led_o,
	output logic                      master_restart_led_o,
	output logic                      aux_restart_led_o
);
	import ssf_pkg::*;

	// Binary to packed decimal digits; 8191 fits in four digits
	function automatic logic [15:0] ssf_to_bcd(input logic [12:0] bin);
		logic [28:0] sh;
		sh = {16'h0000, bin};
		for (int i = 0; i < 13; i++) begin
			for (int d = 0; d < 4; d++) begin
				if (sh[13+4*d +: 4] > 4'h4)
					sh[13+4*d +: 4] = sh[13+4*d +: 4] + 4'h3;
			end
			sh = {sh[27:0], 1'b0};
		end
		return sh[28:13];
	endfunction : ssf_to_bcd

	typedef struct packed {
		logic [9:0]        sync1;
		logic [9:0]        sync2;
		logic [12:0]       mask;
		logic [12:0]       latched;
		logic [12:0]       failure;
		logic              pwr_up;
		logic [12:0]       live_reg;
		logic              mistake;
		logic [3:0]        code;
		logic              ans_valid;
		ssf_src_t          ans_src;
		logic [12:0]       ans_value;
		logic [15:0]       ans_bcd;
		logic              led_green;
		logic              led_master;
		logic              led_aux;
	} ssf_state_t;

	ssf_state_t s_q;
	ssf_state_t s_d;
	logic [12:0] live;
	logic [12:0] mlive;
	logic [12:0] lat_in;
	logic        any_mistake;
	logic [3:0]  new_code;

	// Live view built from synchronised pins plus the mistake and power-up flags; bit 2 is tied low
	always_comb begin
		live                    = '0;
		live[BIT_CONST_VOLTAGE] = s_q.sync2[0];
		live[BIT_CONST_CURRENT] = s_q.sync2[1];
		live[BIT_HIGH_V_TRIP]   = s_q.sync2[2];
		live[BIT_THERMAL_TRIP]  = s_q.sync2[3];
		live[BIT_EXT_SHUTDOWN]  = s_q.sync2[4];
		live[BIT_LIMIT_BACKOFF] = s_q.sync2[5];
		live[BIT_PROG_MISTAKE]  = s_q.mistake;
		live[BIT_POWER_UP]      = s_q.pwr_up;
		live[BIT_HOST_CONTROL]  = s_q.sync2[6];
		live[BIT_MAINS_FAIL]    = s_q.sync2[7];
		live[BIT_OUTPUT_FAIL]   = s_q.sync2[8];
		live[BIT_SENSE_TRIP]    = s_q.sync2[9];
		mlive                   = live & s_q.mask;
	end

	// Lowest code wins when several mistakes land together
	always_comb begin
		any_mistake = 1'b1;
		if (bad_char_i)
			new_code = CODE_BAD_CHAR;
		else if (out_of_range_i)
			new_code = CODE_OUT_OF_RANGE;
		else if (over_soft_limit_i)
			new_code = CODE_OVER_SOFT_LIM;
		else if (bad_soft_limit_i || ceiling_reject_i)
			new_code = CODE_BAD_SOFT_LIM;
		else if (talk_no_query_i)
			new_code = CODE_TALK_NO_QUERY;
		else if (trip_below_output_i)
			new_code = CODE_TRIP_BELOW;
		else if (aux_cpu_timeout_i)
			new_code = CODE_AUX_TIMEOUT;
		else if (cal_locked_i)
			new_code = CODE_CAL_LOCKED;
		else begin
			new_code    = CODE_NONE;
			any_mistake = 1'b0;
		end
	end

	always_comb begin
		s_d       = s_q;
		s_d.sync1 = {sense_trip_flag_i, output_fail_flag_i,
			mains_fail_flag_i, host_control_flag_i,
			limit_backoff_flag_i, ext_shutdown_flag_i,
			thermal_trip_flag_i, high_voltage_trip_flag_i,
			const_current_flag_i, const_voltage_flag_i};
		s_d.sync2 = s_q.sync1;
		// Live view is registered so the output comes from a flop
		s_d.live_reg = live;
		if (mask_wr_i)
			s_d.mask = mask_data_i & ~LIVE_ZERO_MASK;

		// Mistake flag and code: a new mistake beats the clearing query
		if (mistake_code_query_i) begin
			s_d.mistake = 1'b0;
			s_d.code    = CODE_NONE;
		end
		if (any_mistake) begin
			s_d.mistake = 1'b1;
			s_d.code    = new_code;
		end

		// Clear-on-read registers; new conditions survive the clear
		if (latched_state_query_i) begin
			s_d.latched = '0;
			s_d.pwr_up  = 1'b0;
		end
		// The flag is still set while its query is taken; keep it out
		lat_in = mlive;
		if (mistake_code_query_i) begin
			s_d.latched[BIT_PROG_MISTAKE] = 1'b0;
			lat_in[BIT_PROG_MISTAKE]      = 1'b0;
		end
		s_d.latched = s_d.latched | lat_in;
		if (any_mistake)
			s_d.latched[BIT_PROG_MISTAKE] = 1'b1;
		if (failure_query_i)
			s_d.failure = '0;
		s_d.failure = (s_d.failure | mlive) & ~FAIL_ZERO_MASK;

		// One answer per cycle; parser issues one query at a time
		s_d.ans_valid = latched_state_query_i | live_state_query_i |
			failure_query_i | mistake_code_query_i;
		if (latched_state_query_i) begin
			s_d.ans_src   = SSF_SRC_LATCHED;
			s_d.ans_value = s_q.latched;
		end else if (live_state_query_i) begin
			s_d.ans_src   = SSF_SRC_LIVE;
			s_d.ans_value = live;
		end else if (failure_query_i) begin
			s_d.ans_src   = SSF_SRC_FAILURE;
			s_d.ans_value = s_q.failure;
		end else if (mistake_code_query_i) begin
			s_d.ans_src   = SSF_SRC_MISTAKE;
			s_d.ans_value = {9'h000, s_q.code};
		end
		s_d.ans_bcd = ssf_to_bcd(s_d.ans_value);

		// Indicators: an event in the reset-command cycle keeps its LED
		if (reset_cmd_i) begin
			s_d.led_green  = 1'b0;
			s_d.led_master = 1'b0;
			s_d.led_aux    = 1'b0;
		end
		if (opcode_recovery_i)
			s_d.led_green = 1'b1;
		if (master_restart_i)
			s_d.led_master = 1'b1;
		if (aux_restart_i)
			s_d.led_aux = 1'b1;
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q         <= '0;
			s_q.mask    <= MASK_RESET;
			s_q.latched <= LATCHED_RESET;
			s_q.pwr_up  <= 1'b1;
			s_q.code    <= CODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	assign answer_valid_o               = s_q.ans_valid;
	assign answer_src_o                 = s_q.ans_src;
	assign answer_value_o               = s_q.ans_value;
	assign answer_bcd_o                 = s_q.ans_bcd;
	assign latched_condition_register_o = s_q.latched;
	assign failure_condition_register_o = s_q.failure;
	assign cond_mask_o                  = s_q.mask;
	assign serial_poll_mistake_o        = s_q.mistake;
	assign error_led_o                  = s_q.mistake;
	assign watchdog_recovery_led_o      = s_q.led_green;
	assign master_restart_led_o         = s_q.led_master;
	assign aux_restart_led_o            = s_q.led_aux;

	assign live_condition_register_o    = s_q.live_reg;

	a_fail_zero_bits: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(failure_condition_register_o & FAIL_ZERO_MASK) == '0)
		else $error("failure register shows power-up or host bits");
	a_unused_bit_zero: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!latched_condition_register_o[BIT_UNUSED] &&
		!live_condition_register_o[BIT_UNUSED])
		else $error("unused bit 2 set");
	a_latched_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
		latched_state_query_i |=> answer_valid_o &&
		answer_value_o == $past(latched_condition_register_o))
		else $error("latched answer wrong");
	a_latched_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
		latched_state_query_i && !any_mistake |=>
		(latched_condition_register_o & ~$past(mlive)) == '0)
		else $error("latched register not cleared by its query");
	a_failure_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
		failure_query_i |=> (failure_condition_register_o &
		~$past(mlive)) == '0)
		else $error("failure register not cleared by its query");
	a_mistake_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mistake_code_query_i && !latched_state_query_i &&
		!live_state_query_i && !failure_query_i |=>
		answer_value_o == {9'h000, $past(s_q.code)})
		else $error("mistake code answer wrong");
	a_mistake_cleared: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mistake_code_query_i && !any_mistake |=>
		!serial_poll_mistake_o && s_q.code == CODE_NONE)
		else $error("mistake flag not cleared");
	a_mistake_latched: assert property (@(posedge clk_i) disable iff (!resetn_i)
		mistake_code_query_i && !any_mistake |=>
		!latched_condition_register_o[BIT_PROG_MISTAKE])
		else $error("mistake bit not cleared in latched register");
	a_code_bad_char: assert property (@(posedge clk_i) disable iff (!resetn_i)
		bad_char_i |=> s_q.code == CODE_BAD_CHAR && error_led_o)
		else $error("code 4 not recorded");
	a_ceiling_reject: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ceiling_reject_i |=> latched_condition_register_o[BIT_PROG_MISTAKE]
		&& error_led_o)
		else $error("rejected ceiling not flagged");
	a_led_green_set: assert property (@(posedge clk_i) disable iff (!resetn_i)
		opcode_recovery_i |=> watchdog_recovery_led_o)
		else $error("green indicator not lit");
	a_led_reset_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
		reset_cmd_i && !opcode_recovery_i && !master_restart_i &&
		!aux_restart_i |=> !watchdog_recovery_led_o &&
		!master_restart_led_o && !aux_restart_led_o)
		else $error("indicators not cleared by reset command");
	a_shutdown_live: assert property (@(posedge clk_i) disable iff (!resetn_i)
		ext_shutdown_flag_i [*4] |->
		live_condition_register_o[BIT_EXT_SHUTDOWN])
		else $error("shutdown not reported");
	a_bcd_answer: assert property (@(posedge clk_i) disable iff (!resetn_i)
		answer_valid_o |-> answer_bcd_o[3:0] < 4'ha &&
		answer_bcd_o[3:0] == 4'(answer_value_o % 13'd10))
		else $error("decimal digits wrong");
endmodule : ssf_regs
